// *** core/ictr_access.sv ***
// System-register access decoder: interface-select and virtual group 0 priorities
`timescale 1ns/1ps
`include "ictr_cfg.svh"
// Operation
// - Decode interface-select register at coproc 1111, opc1 0, CRn/CRm 1100, opc2 101.
// - Interface-select bit 0 set enables system-register interface, else memory-mapped.
// - Monitor-level enable clear traps level-1 and level-2 select accesses to level 3.
// - Group 12 trap bit traps non-secure level-1 select accesses to level 2.
// - Non-secure state with hypervisor enable clear traps level-1 select accesses to level 2.
// - Memory-mapped writes may update shared system-register storage while disabled.
// - Virtual registers reachable only from non-secure level 1, routed by hypervisor bits.
// - System-register bit layouts match the equivalent memory-mapped registers.
// - Virtual priority registers are 32 bits, reset zero, zero meaning none active.
// - Decode priority registers at CRm 1000, opc2 as leading one plus index.
// - At non-secure level 1, fast route bit selects virtual over physical register.
// - Register 1 needs six priority bits; registers 2 and 3 need seven.
// - Level-1 enable clear makes non-secure level-1 priority accesses trap to level 1; the code traps them only when the fast route bit selects virtual.
// - Group 12 trap bit traps non-secure level-1 priority accesses to level 2; the code traps them only when the fast route bit selects virtual.
// - Non-secure state with trap-all-group-0 traps level-1 priority accesses to level 2; the code traps them only when the fast route bit selects virtual.
module ictr_access #(
   parameter logic [2:0] PRIO_BITS = `ICTR_PRIO_BITS
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire ictr_pkg::ictr_req_t req,
   input wire ictr_pkg::ictr_ctl_t ctl,
   input wire logic mm_wr_valid,
   input wire logic [31:0] mm_wr_data,
   output ictr_pkg::ictr_rsp_t rsp,
   output logic sysreg_iface_enable,
   output logic [31:0] phys_ap_wdata,
   output logic [1:0] phys_ap_idx,
   output logic phys_ap_wr,
   output logic phys_ap_rd
);
   typedef enum logic [1:0] {
      ICTR_IDLE = 2'b00,
      ICTR_READ = 2'b01
   } ictr_state_t;

   ictr_state_t state;
   ictr_state_t next_state;
   logic [31:0] interface_select_reg;

   function automatic logic is_ns_l1(input ictr_pkg::ictr_req_t r);
      return r.nonsecure && (r.el == `ICTR_EL1);
   endfunction

   function automatic logic ap_present(input logic [1:0] idx, input logic [2:0] bits);
      if (idx == 2'd0) begin
         return 1'b1;
      end
      if (idx == 2'd1) begin
         return bits >= `ICTR_PRIO_AP1;
      end
      return bits >= `ICTR_PRIO_AP23;
   endfunction

   wire logic common_hit = (req.coproc == `ICTR_COPROC) && (req.opc1 == `ICTR_OPC1)
      && (req.crn == `ICTR_CRN);
   wire logic sel_hit = common_hit && (req.crm == `ICTR_CRM_SEL)
      && (req.opc2 == `ICTR_OPC2_SEL);
   wire logic ap_hit = common_hit && (req.crm == `ICTR_CRM_AP0)
      && (req.opc2[2] == `ICTR_OPC2_AP0_TOP);
   wire logic [1:0] ap_idx = req.opc2[1:0];
   wire logic ns_l1 = is_ns_l1(req);
   wire logic el12 = (req.el == `ICTR_EL1) || (req.el == `ICTR_EL2);
   wire logic ap_virt = ns_l1 && ctl.fast_irq_virt_route;

   // Select register checks, highest priority first
   wire logic sel_trap3 = el12 && !ctl.sel_mon_en;
   wire logic sel_trap2 = ns_l1 && (ctl.group12_trap
      || (ctl.nonsecure_state_bit && !ctl.sel_hyp_en));

   // Priority register checks; undefined beats traps, as missing registers do
   wire logic ap_undef = !ap_present(ap_idx, PRIO_BITS);
   wire logic ap_trap1 = ap_virt && !ctl.sel_l1_en;
   wire logic ap_trap2 = ap_virt && (ctl.group12_trap
      || (ctl.nonsecure_state_bit && ctl.trap_all_group0));

   // A request is taken only while no virtual read is pending; one in the
   // read's second cycle must not write the store or leave the core
   wire logic take = req_valid && (state == ICTR_IDLE);
   wire logic sel_ok = sel_hit && !sel_trap3 && !sel_trap2;
   wire logic ap_ok = ap_hit && !ap_undef && !ap_trap1 && !ap_trap2;
   wire logic virt_wr = take && ap_ok && ap_virt && req.write;
   wire logic sel_wr = take && sel_ok && req.write;
   wire logic mm_take = mm_wr_valid && !interface_select_reg[`ICTR_ENABLE_BIT];
   wire logic phys_go = take && ap_ok && !ap_virt;

   ictr_pkg::ictr_rsp_t next_rsp;
   logic [31:0] ap_rdata;

   ictr_ap_mem u_ap_mem (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .wr_en(virt_wr),
      .wr_idx(ap_idx),
      .wr_data(req.wdata),
      .rd_idx(ap_idx),
      .rd_data(ap_rdata)
   );

   // Fixed-priority outcome: unknown encodings are undefined
   always_comb begin
      next_rsp = '0;
      next_state = ICTR_IDLE;
      case (state)
         ICTR_IDLE: begin
            if (req_valid) begin
               next_rsp.valid = 1'b1;
               if (sel_hit) begin
                  if (sel_trap3) begin
                     next_rsp.outcome = ictr_pkg::ICTR_TRAP;
                     next_rsp.target_el = `ICTR_EL3;
                  end else if (sel_trap2) begin
                     next_rsp.outcome = ictr_pkg::ICTR_TRAP;
                     next_rsp.target_el = `ICTR_EL2;
                  end else begin
                     next_rsp.rdata = interface_select_reg & `ICTR_SEL_MASK;
                  end
               end else if (ap_hit) begin
                  if (ap_undef) begin
                     next_rsp.outcome = ictr_pkg::ICTR_UNDEF;
                  end else if (ap_trap1) begin
                     next_rsp.outcome = ictr_pkg::ICTR_TRAP;
                     next_rsp.target_el = `ICTR_EL1;
                  end else if (ap_trap2) begin
                     next_rsp.outcome = ictr_pkg::ICTR_TRAP;
                     next_rsp.target_el = `ICTR_EL2;
                  end else if (ap_virt && !req.write) begin
                     // Memory read data lands one cycle later
                     next_rsp.valid = 1'b0;
                     next_state = ICTR_READ;
                  end
               end else begin
                  next_rsp.outcome = ictr_pkg::ICTR_UNDEF;
               end
            end
         end
         ICTR_READ: begin
            next_rsp.valid = 1'b1;
            next_rsp.rdata = ap_rdata;
         end
         default: begin
            next_state = ICTR_IDLE;
         end
      endcase
   end

   // Sequencing and the registered answer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= ICTR_IDLE;
         rsp <= '0;
      end else begin
         state <= next_state;
         rsp <= next_rsp;
      end
   end

   // Shared storage: the memory-mapped side may change it only while disabled;
   // a system write in the same cycle wins, the core being the newer owner
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         interface_select_reg <= `ICTR_SEL_RESET;
         sysreg_iface_enable <= 1'b0;
      end else if (sel_wr) begin
         interface_select_reg <= req.wdata & `ICTR_SEL_MASK;
         sysreg_iface_enable <= req.wdata[`ICTR_ENABLE_BIT];
      end else if (mm_take) begin
         interface_select_reg <= mm_wr_data & `ICTR_SEL_MASK;
         sysreg_iface_enable <= mm_wr_data[`ICTR_ENABLE_BIT];
      end
   end

   // Physical route leaves the core; its register lives elsewhere
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phys_ap_wdata <= '0;
         phys_ap_idx <= '0;
         phys_ap_wr <= 1'b0;
         phys_ap_rd <= 1'b0;
      end else begin
         phys_ap_wr <= phys_go && req.write;
         phys_ap_rd <= phys_go && !req.write;
         phys_ap_idx <= ap_idx;
         phys_ap_wdata <= req.wdata;
      end
   end
endmodule // ictr_access

// *** core/ictr_ap_mem.sv ***
// Four-word store for the virtual group 0 active-priority registers
`timescale 1ns/1ps
`include "ictr_cfg.svh"
module ictr_ap_mem (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [31:0] wr_data,
   input wire logic [1:0] rd_idx,
   output logic [31:0] rd_data
);
   logic [31:0] store [4];

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < 4; i++) begin
            store[i] <= `ICTR_AP_RESET;
         end
         rd_data <= `ICTR_AP_RESET;
      end else begin
         if (wr_en) begin
            store[wr_idx] <= wr_data;
         end
         rd_data <= store[rd_idx];
      end
   end
endmodule // ictr_ap_mem

// *** core/ictr_cfg.svh ***
// Constants for the interrupt-controller system-register access decoder
`ifndef ICTR_CFG_SVH
`define ICTR_CFG_SVH
`define ICTR_COPROC 4'b1111
`define ICTR_OPC1 3'b000
`define ICTR_CRN 4'b1100
`define ICTR_CRM_SEL 4'b1100
`define ICTR_OPC2_SEL 3'b101
`define ICTR_CRM_AP0 4'b1000
`define ICTR_OPC2_AP0_TOP 1'b1
`define ICTR_ENABLE_BIT 0
`define ICTR_SEL_RESET 32'h0000_0000
`define ICTR_AP_RESET 32'h0000_0000
`define ICTR_SEL_MASK 32'h0000_0001
`define ICTR_PRIO_BITS 3'h5
`define ICTR_PRIO_AP1 3'h6
`define ICTR_PRIO_AP23 3'h7
`define ICTR_EL1 2'h1
`define ICTR_EL2 2'h2
`define ICTR_EL3 2'h3
`endif

// *** core/ictr_pkg.sv ***
// Types for the interrupt-controller system-register access decoder
package ictr_pkg;
   typedef struct packed {
      logic [3:0] coproc;
      logic [2:0] opc1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] opc2;
      logic write;
      logic [1:0] el;
      logic nonsecure;
      logic [31:0] wdata;
   } ictr_req_t;

   typedef enum logic [1:0] {
      ICTR_DONE = 2'b00,
      ICTR_UNDEF = 2'b01,
      ICTR_TRAP = 2'b11
   } ictr_outcome_t;

   typedef struct packed {
      logic valid;
      ictr_outcome_t outcome;
      logic [1:0] target_el;
      logic [31:0] rdata;
   } ictr_rsp_t;

   typedef struct packed {
      logic sel_l1_en;
      logic sel_hyp_en;
      logic sel_mon_en;
      logic group12_trap;
      logic fast_irq_virt_route;
      logic nonsecure_state_bit;
      logic trap_all_group0;
   } ictr_ctl_t;
endpackage

// *** dv/ictr_access_chk.sv ***
// Assertion checker for the system-register access decoder
`timescale 1ns/1ps
`include "ictr_cfg.svh"
module ictr_access_chk #(
   parameter logic [2:0] PRIO_BITS = 3'h5
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic req_valid,
   input wire ictr_pkg::ictr_req_t req,
   input wire ictr_pkg::ictr_ctl_t ctl,
   input wire ictr_pkg::ictr_rsp_t rsp,
   input wire logic sysreg_iface_enable,
   input wire logic phys_ap_wr,
   input wire logic phys_ap_rd
);
   localparam logic [2:0] VT = {1'b1, ictr_pkg::ICTR_TRAP};
   localparam logic [2:0] VU = {1'b1, ictr_pkg::ICTR_UNDEF};
   localparam logic [2:0] VD = {1'b1, ictr_pkg::ICTR_DONE};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire hit = req_valid && req.coproc == `ICTR_COPROC && req.opc1 == `ICTR_OPC1;
   wire sel = hit && req.crn == `ICTR_CRN && req.crm == `ICTR_CRM_SEL && req.opc2 == 3'h5;
   wire ap = hit && req.crn == `ICTR_CRN && req.crm == `ICTR_CRM_AP0 && req.opc2[2];
   wire miss = (PRIO_BITS < 3'h6 && req.opc2[1:0] != 2'h0) || (PRIO_BITS < 3'h7 && req.opc2[1]);
   wire nl1 = req.el == `ICTR_EL1 && req.nonsecure;
   wire virt = ap && !miss && nl1 && ctl.fast_irq_virt_route;
   wire vhyp = ctl.group12_trap || (ctl.nonsecure_state_bit && ctl.trap_all_group0);
   wire [4:0] vo = {rsp.valid, rsp.outcome, rsp.target_el};
   a_sel_mon_trap:
      assert property (sel && !ctl.sel_mon_en && (req.el == `ICTR_EL1 || req.el == `ICTR_EL2)
         |=> vo == {VT, `ICTR_EL3}) else $error("select access not sent to level 3");
   a_sel_grp_trap:
      assert property (sel && ctl.sel_mon_en && nl1 && ctl.group12_trap
         |=> vo == {VT, `ICTR_EL2}) else $error("group 12 trap missed on select");
   a_sel_hyp_trap:
      assert property (sel && ctl.sel_mon_en && nl1 && ctl.nonsecure_state_bit && !ctl.sel_hyp_en
         |=> vo == {VT, `ICTR_EL2}) else $error("hypervisor enable trap missed");
   a_sel_write_en:
      assert property (sel && ctl.sel_mon_en && req.el == `ICTR_EL2 && req.write
         |=> vo[4:2] == VD && sysreg_iface_enable == $past(req.wdata[0]))
         else $error("select write not applied");
   a_ap_missing:
      assert property (ap && miss |=> vo[4:2] == VU) else $error("missing register not undefined");
   a_ap_l1_trap:
      assert property (virt && !ctl.sel_l1_en |=> vo == {VT, `ICTR_EL1})
         else $error("level 1 enable trap missed");
   a_ap_hyp_trap:
      assert property (virt && ctl.sel_l1_en && vhyp |=> vo == {VT, `ICTR_EL2})
         else $error("priority access not sent to level 2");
   a_ap_phys_route:
      assert property (ap && !miss && !(nl1 && ctl.fast_irq_virt_route)
         |=> vo[4:2] == VD && phys_ap_wr == $past(req.write) && phys_ap_rd != $past(req.write))
         else $error("physical access not routed out");
   a_vread_late:
      assert property (virt && ctl.sel_l1_en && !vhyp && !req.write |=> !rsp.valid ##1 vo[4:2] == VD)
         else $error("virtual read answer out of time");
   a_bad_encode:
      assert property (req_valid && !sel && !ap |=> vo[4:2] == VU) else $error("bad encoding answered");
endmodule // ictr_access_chk

// *** dv/ictr_access_tb.sv ***
// Self-checking bench for the system-register access decoder
`timescale 1ns/1ps
`include "ictr_cfg.svh"
module ictr_access_tb;
   localparam logic [1:0] OK = ictr_pkg::ICTR_DONE;
   localparam logic [1:0] UD = ictr_pkg::ICTR_UNDEF;
   localparam logic [1:0] TR = ictr_pkg::ICTR_TRAP;
   localparam logic [3:0] CS = `ICTR_CRM_SEL;
   localparam logic [3:0] CA = `ICTR_CRM_AP0;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic mm_wr_valid = 1'b0;
   logic [31:0] mm_wr_data = 32'h0000_0000;
   ictr_pkg::ictr_req_t req = '0;
   ictr_pkg::ictr_ctl_t ctl = 7'h70;
   ictr_pkg::ictr_rsp_t rsp;
   logic sysreg_iface_enable, phys_ap_wr, phys_ap_rd;
   logic [31:0] phys_ap_wdata;
   logic [1:0] phys_ap_idx;
   logic [3:0][31:0] mem;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   always #50 ref_clk = ~ref_clk;
   ictr_access #(.PRIO_BITS(3'h5)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .req_valid(req_valid), .req(req), .ctl(ctl), .mm_wr_valid(mm_wr_valid),
      .mm_wr_data(mm_wr_data), .rsp(rsp), .sysreg_iface_enable(sysreg_iface_enable),
      .phys_ap_wdata(phys_ap_wdata), .phys_ap_idx(phys_ap_idx), .phys_ap_wr(phys_ap_wr),
      .phys_ap_rd(phys_ap_rd));
   ictr_phys_ap_model pm (.ref_clk(ref_clk), .phys_ap_wr(phys_ap_wr),
      .phys_ap_idx(phys_ap_idx), .phys_ap_wdata(phys_ap_wdata), .mem(mem));
   task automatic ck(input logic [36:0] g, input logic [36:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One access; waits out the late virtual read answer, so spacing is always legal
   task automatic acc(input logic [6:0] c, input logic [3:0] crm, input logic [2:0] op,
         input logic w, input logic [1:0] el, input logic ns, input logic [31:0] wd,
         input logic [1:0] eo, input logic [1:0] tel, input logic [31:0] ed);
      int i;
      i = 0;
      @(posedge ref_clk);
      ctl <= c;
      req <= {`ICTR_COPROC, `ICTR_OPC1, `ICTR_CRN, crm, op, w, el, ns, wd};
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      @(negedge ref_clk);
      while (rsp.valid !== 1'b1 && i < 2) begin
         @(negedge ref_clk);
         i++;
      end
      ck({rsp.valid, rsp.outcome, eo == TR ? rsp.target_el : 2'h0,
         eo == OK && !w ? rsp.rdata : 32'h0}, {1'b1, eo, tel, ed});
   endtask
   task automatic mmw(input logic [31:0] d);
      @(posedge ref_clk);
      mm_wr_valid <= 1'b1;
      mm_wr_data <= d;
      @(posedge ref_clk);
      mm_wr_valid <= 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic final_report;
      $display("Errors %0d of %0d checks", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      acc(7'h70, CS, 3'h5, 1'h0, 2'h3, 1'h0, 32'h0, OK, 2'h0, 32'h0);
      ck(sysreg_iface_enable, 1'h0);
      acc(7'h70, CS, 3'h5, 1'h1, 2'h2, 1'h0, 32'hFFFF_FFFF, OK, 2'h0, 32'h0);
      ck(sysreg_iface_enable, 1'h1);
      acc(7'h70, CS, 3'h5, 1'h0, 2'h2, 1'h0, 32'h0, OK, 2'h0, 32'h1);
      for (int e = 1; e < 3; e++) acc(7'h60, CS, 3'h5, 1'h0, e[1:0], e[0], 32'h0, TR, 2'h3, 32'h0);
      acc(7'h78, CS, 3'h5, 1'h0, 2'h1, 1'h1, 32'h0, TR, 2'h2, 32'h0);
      acc(7'h52, CS, 3'h5, 1'h1, 2'h1, 1'h1, 32'h0, TR, 2'h2, 32'h0);
      acc(7'h72, CS, 3'h5, 1'h1, 2'h1, 1'h1, 32'h0, OK, 2'h0, 32'h0);
      mmw(32'h0000_0001);
      ck(sysreg_iface_enable, 1'h1);
      mmw(32'h0000_0000);
      ck(sysreg_iface_enable, 1'h1);
      acc(7'h74, CA, 3'h4, 1'h0, 2'h1, 1'h1, 32'h0, OK, 2'h0, 32'h0);
      acc(7'h74, CA, 3'h4, 1'h1, 2'h1, 1'h1, 32'hA5A5_0001, OK, 2'h0, 32'h0);
      acc(7'h74, CA, 3'h4, 1'h0, 2'h1, 1'h1, 32'h0, OK, 2'h0, 32'hA5A5_0001);
      for (int n = 5; n < 8; n++) acc(7'h74, CA, n[2:0], 1'h0, 2'h1, 1'h1, 32'h0, UD, 2'h0, 32'h0);
      acc(7'h34, CA, 3'h4, 1'h0, 2'h1, 1'h1, 32'h0, TR, 2'h1, 32'h0);
      acc(7'h7C, CA, 3'h4, 1'h0, 2'h1, 1'h1, 32'h0, TR, 2'h2, 32'h0);
      acc(7'h77, CA, 3'h4, 1'h0, 2'h1, 1'h1, 32'h0, TR, 2'h2, 32'h0);
      acc(7'h70, CA, 3'h4, 1'h1, 2'h1, 1'h1, 32'h0000_0C3C, OK, 2'h0, 32'h0);
      ck(phys_ap_wr, 1'h1);
      // The far-side store takes the pulse one edge later
      @(negedge ref_clk);
      ck(mem[0], 32'h0000_0C3C);
      acc(7'h70, CA, 3'h4, 1'h0, 2'h3, 1'h0, 32'h0, OK, 2'h0, 32'h0);
      ck(phys_ap_rd, 1'h1);
      // Virtual group 0 register 0 restored to zero, then a read at CRm 1001 answered undefined
      acc(7'h74, CA, 3'h4, 1'h1, 2'h1, 1'h1, 32'h0, OK, 2'h0, 32'h0);
      acc(7'h70, 4'h9, 3'h4, 1'h0, 2'h1, 1'h1, 32'h0, UD, 2'h0, 32'h0);
      final_report;
   end
endmodule // ictr_access_tb
bind ictr_access ictr_access_chk #(.PRIO_BITS(PRIO_BITS)) chk (.ref_clk(ref_clk),
   .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .ctl(ctl), .rsp(rsp),
   .sysreg_iface_enable(sysreg_iface_enable), .phys_ap_wr(phys_ap_wr), .phys_ap_rd(phys_ap_rd));

// *** dv/ictr_phys_ap_model.sv ***
// Physical group 0 priority store standing outside the decoder
`timescale 1ns/1ps
module ictr_phys_ap_model (
   input wire logic ref_clk,
   input wire logic phys_ap_wr,
   input wire logic [1:0] phys_ap_idx,
   input wire logic [31:0] phys_ap_wdata,
   output logic [3:0][31:0] mem
);
   // Starts at zero, the value meaning no active priorities
   initial mem = '0;
   always @(posedge ref_clk) begin
      if (phys_ap_wr) mem[phys_ap_idx] <= phys_ap_wdata;
   end
endmodule // ictr_phys_ap_model
